// file: rf_tx_crc_mode_config_pkg.sv
// constants and types for the general mode and transmit mode configuration block
// What the document requires
// R1 - CRC high bit order bit set: standalone CRC shifts data MSB first
// R2 - with MSB first, both CRC result bytes are shown bit reversed
// R3 - CRC bit order is ignored while RF communication runs
// R4 - wait-for-field set: transmitter starts only while an RF field exists
// R5 - envelope pin is active high when polarity bit is 1, else active low
// R6 - internal envelope is active low; polarity change raises envelope event
// R7 - standalone CRC preset: 00=0000h, 01=6363h, 10=A671h, 11=FFFFh
// R8 - during RF communication preset follows framing, preset field ignored
// R9 - transmit CRC enable set: CRC generated and appended to frames
// R10 - host clears transmit CRC enable only at 106 kBd
// R11 - speed field selects 106, 212, 424, 848 kBd; codes 100-111 reserved
// R12 - modulation invert bit set inverts modulation of transmitted data
// R13 - framing 00 is type A, 11 is type B; 01 and 10 reserved
// R14 - host never writes reserved codes or changes reserved bits; host model restores only the general mode reserved bits
`default_nettype none
package rf_tx_crc_mode_config_pkg;
    localparam logic [5:0]  GEN_MODE_ADDR   = 6'h11;
    localparam logic [5:0]  TX_MODE_ADDR    = 6'h12;
    localparam logic [7:0]  GEN_MODE_RESET  = 8'h3F;
    localparam logic [7:0]  TX_MODE_RESET   = 8'h00;
    localparam logic [7:0]  GEN_RSVD_MASK   = 8'h54;
    localparam logic [7:0]  TX_RSVD_MASK    = 8'h04;
    localparam int          CRC_ORDER_BIT   = 7;
    localparam int          WAIT_FIELD_BIT  = 5;
    localparam int          ENV_POL_BIT     = 3;
    localparam int          PRESET_LSB      = 0;
    localparam int          TX_CRC_BIT      = 7;
    localparam int          RATE_LSB        = 4;
    localparam int          INV_BIT         = 3;
    localparam int          FRAME_LSB       = 0;
    localparam logic [15:0] PRESET_0        = 16'h0000;
    localparam logic [15:0] PRESET_1        = 16'h6363;
    localparam logic [15:0] PRESET_2        = 16'hA671;
    localparam logic [15:0] PRESET_3        = 16'hFFFF;
    localparam logic [15:0] POLY_LSB_FIRST  = 16'h8408;
    localparam logic [15:0] POLY_MSB_FIRST  = 16'h1021;
    localparam int          CLK_NS          = 50;
    localparam int          BIT_106_NS      = 9440;
    localparam int          BIT_212_NS      = 4720;
    localparam int          BIT_424_NS      = 2360;
    localparam int          BIT_848_NS      = 1180;
    localparam logic [7:0]  BIT_106_CYC     = 8'(BIT_106_NS / CLK_NS);
    localparam logic [7:0]  BIT_212_CYC     = 8'(BIT_212_NS / CLK_NS);
    localparam logic [7:0]  BIT_424_CYC     = 8'(BIT_424_NS / CLK_NS);
    localparam logic [7:0]  BIT_848_CYC     = 8'(BIT_848_NS / CLK_NS);

    typedef enum logic [2:0] {
        RATE_106 = 3'h0,
        RATE_212 = 3'h1,
        RATE_424 = 3'h2,
        RATE_848 = 3'h3
    } bit_rate_t;

    typedef enum logic [1:0] {
        FRAME_A = 2'h0,
        FRAME_B = 2'h3
    } frame_t;

    typedef struct packed {
        logic       crc_high_bit_order;
        logic       transmit_wait_for_field;
        logic       envelope_input_polarity;
        logic [1:0] crc_init_select;
    } gen_settings_t;

    typedef struct packed {
        logic       transmit_crc_enable;
        logic [2:0] transmit_bit_rate;
        logic       modulation_invert;
        logic [1:0] transmit_frame_format;
    } tx_settings_t;
endpackage
`default_nettype wire

// file: rf_tx_crc_mode_config.sv
// general mode and transmit mode registers with the CRC coprocessor they steer
`timescale 1ns/1ns
`default_nettype none
module rf_tx_crc_mode_config (
    // clock and reset
    input  wire  logic                                 clk,
    input  wire  logic                                 reset_n,
    // register access from host interface
    input  wire  logic [5:0]                           reg_addr,
    input  wire  logic [7:0]                           reg_wdata,
    input  wire  logic                                 reg_we,
    input  wire  logic                                 reg_re,
    output var   logic [7:0]                           reg_rdata,
    // settings seen by the rest of the device
    output var   rf_tx_crc_mode_config_pkg::gen_settings_t gen_settings,
    output var   rf_tx_crc_mode_config_pkg::tx_settings_t  tx_settings,
    output var   logic                                 tx_code_reserved,
    // rf state from the transceiver
    input  wire  logic                                 rf_active,
    input  wire  logic                                 tx_active,
    input  wire  logic [1:0]                           receive_frame_format,
    input  wire  logic                                 rf_field_on,
    // transmitter start and data path
    input  wire  logic                                 tx_start_req,
    output logic                                       tx_start_grant,
    output var   logic                                 tx_bit_tick,
    input  wire  logic                                 tx_data_mod,
    output var   logic                                 tx_mod_out,
    // envelope pin
    input  wire  logic                                 envelope_input_pin,
    output var   logic                                 envelope_n,
    output var   logic                                 envelope_input_active_event,
    // crc coprocessor
    input  wire  logic                                 crc_compute_command,
    input  wire  logic [7:0]                           crc_data,
    input  wire  logic                                 crc_data_valid,
    output logic                                       crc_ready,
    output var   logic [7:0]                           crc_result_high,
    output var   logic [7:0]                           crc_result_low
);
    import rf_tx_crc_mode_config_pkg::*;

    typedef enum logic {CRC_IDLE, CRC_RUN} crc_state_t;

    gen_settings_t gen_q, gen_d;
    tx_settings_t  tx_q, tx_d;
    logic [7:0]    rdata_q, rdata_d;
    logic          pin_s1_q, pin_s2_q;
    logic          env_n_q, env_n_d;
    logic          env_evt_q, env_evt_d;
    logic [7:0]    tick_cnt_q, tick_cnt_d;
    logic          tick_q, tick_d;
    logic          mod_q, mod_d;
    logic [2:0]    rate_eff;
    logic [7:0]    bit_cycles;
    crc_state_t    crc_st_q, crc_st_d;
    logic [15:0]   crc_q, crc_d;
    logic [7:0]    byte_q, byte_d;
    logic [2:0]    bitcnt_q, bitcnt_d;
    logic          order_q, order_d;
    logic [15:0]   preset;
    logic [1:0]    frame_now;
    logic          in_bit, fb;
    logic [7:0]    gen_rd, tx_rd;
    logic [7:0]    rev_hi, rev_lo;
    logic [1:0]    alive_q;

    // register write, readback
    always_comb begin
        gen_d   = gen_q;
        tx_d    = tx_q;
        rdata_d = rdata_q;
        gen_rd  = GEN_MODE_RESET & GEN_RSVD_MASK;
        gen_rd[CRC_ORDER_BIT]  = gen_q.crc_high_bit_order;
        gen_rd[WAIT_FIELD_BIT] = gen_q.transmit_wait_for_field;
        gen_rd[ENV_POL_BIT]    = gen_q.envelope_input_polarity;
        gen_rd[PRESET_LSB+:2]  = gen_q.crc_init_select;
        tx_rd   = 8'h00;
        tx_rd[TX_CRC_BIT]      = tx_q.transmit_crc_enable;
        tx_rd[RATE_LSB+:3]     = tx_q.transmit_bit_rate;
        tx_rd[INV_BIT]         = tx_q.modulation_invert;
        tx_rd[FRAME_LSB+:2]    = tx_q.transmit_frame_format;
        if (reg_we && reg_addr == GEN_MODE_ADDR) begin
            gen_d.crc_high_bit_order      = reg_wdata[CRC_ORDER_BIT];
            gen_d.transmit_wait_for_field = reg_wdata[WAIT_FIELD_BIT];
            gen_d.envelope_input_polarity = reg_wdata[ENV_POL_BIT];
            gen_d.crc_init_select         = reg_wdata[PRESET_LSB+:2];
        end else if (reg_we && reg_addr == TX_MODE_ADDR) begin
            tx_d.transmit_crc_enable   = reg_wdata[TX_CRC_BIT];
            tx_d.transmit_bit_rate     = reg_wdata[RATE_LSB+:3];
            tx_d.modulation_invert     = reg_wdata[INV_BIT];
            tx_d.transmit_frame_format = reg_wdata[FRAME_LSB+:2];
        end
        if (reg_re) begin
            if (reg_addr == GEN_MODE_ADDR) begin
                rdata_d = gen_rd;
            end else if (reg_addr == TX_MODE_ADDR) begin
                rdata_d = tx_rd;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gen_q   <= gen_settings_t'({GEN_MODE_RESET[7], GEN_MODE_RESET[5],
                                        GEN_MODE_RESET[3], GEN_MODE_RESET[1:0]});
            tx_q    <= tx_settings_t'({TX_MODE_RESET[7:3], TX_MODE_RESET[1:0]});
            rdata_q <= 8'h00;
        end else begin
            gen_q   <= gen_d;
            tx_q    <= tx_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata    = rdata_q;
    assign gen_settings = gen_q;
    assign tx_settings  = tx_q; // see R9 see R13
    assign tx_code_reserved = (tx_q.transmit_bit_rate > 3'(RATE_848))
        || (tx_q.transmit_frame_format != FRAME_A && tx_q.transmit_frame_format != FRAME_B);

    // start only with field present when asked to wait
    assign tx_start_grant = tx_start_req
        && (!gen_q.transmit_wait_for_field || rf_field_on); // see R4

    // envelope pin: sync, fold polarity into active-low form
    always_comb begin
        env_n_d   = gen_q.envelope_input_polarity ? ~pin_s2_q : pin_s2_q; // see R5 see R6
        env_evt_d = reg_we && reg_addr == GEN_MODE_ADDR
            && reg_wdata[ENV_POL_BIT] != gen_q.envelope_input_polarity; // see R6
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q  <= 1'b0;
            pin_s2_q  <= 1'b0;
            env_n_q   <= 1'b1;
            env_evt_q <= 1'b0;
        end else begin
            pin_s1_q  <= envelope_input_pin;
            pin_s2_q  <= pin_s1_q;
            env_n_q   <= env_n_d;
            env_evt_q <= env_evt_d;
        end
    end

    assign envelope_n                  = env_n_q;
    assign envelope_input_active_event = env_evt_q;

    // bit-rate enable and modulation polarity
    always_comb begin
        rate_eff = tx_q.transmit_bit_rate;
        case (rate_eff)
            RATE_212: bit_cycles = BIT_212_CYC;
            RATE_424: bit_cycles = BIT_424_CYC;
            RATE_848: bit_cycles = BIT_848_CYC;
            default:  bit_cycles = BIT_106_CYC;
        endcase
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q;
        if (!tx_active) begin
            tick_cnt_d = bit_cycles - 8'h01;
        end else if (tick_cnt_q == 8'h00) begin
            tick_d     = 1'b1;
            tick_cnt_d = bit_cycles - 8'h01; // see R11
        end else begin
            tick_cnt_d = tick_cnt_q - 8'h01;
        end
        mod_d = tx_data_mod ^ tx_q.modulation_invert; // see R12
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 8'h00;
            tick_q     <= 1'b0;
            mod_q      <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
            mod_q      <= mod_d;
        end
    end

    assign tx_bit_tick = tick_q;
    assign tx_mod_out  = mod_q;

    // crc coprocessor: one bit per clock
    always_comb begin
        frame_now = tx_active ? tx_q.transmit_frame_format : receive_frame_format;
        if (rf_active) begin
            preset = (frame_now == FRAME_B) ? PRESET_3 : PRESET_1; // see R8
        end else begin
            case (gen_q.crc_init_select) // see R7
                2'h0:    preset = PRESET_0;
                2'h1:    preset = PRESET_1;
                2'h2:    preset = PRESET_2;
                default: preset = PRESET_3;
            endcase
        end
        in_bit   = order_q ? byte_q[7] : byte_q[0]; // see R1
        fb       = order_q ? (crc_q[15] ^ in_bit) : (crc_q[0] ^ in_bit);
        crc_st_d = crc_st_q;
        crc_d    = crc_q;
        byte_d   = byte_q;
        bitcnt_d = bitcnt_q;
        order_d  = order_q;
        case (crc_st_q)
            CRC_IDLE: begin
                if (crc_compute_command) begin
                    crc_d   = preset;
                    order_d = gen_q.crc_high_bit_order && !rf_active; // see R3
                end else if (crc_data_valid) begin
                    byte_d   = crc_data;
                    bitcnt_d = 3'h0;
                    crc_st_d = CRC_RUN;
                end
            end
            default: begin
                if (order_q) begin
                    crc_d  = {crc_q[14:0], 1'b0} ^ (fb ? POLY_MSB_FIRST : 16'h0000);
                    byte_d = {byte_q[6:0], 1'b0};
                end else begin
                    crc_d  = {1'b0, crc_q[15:1]} ^ (fb ? POLY_LSB_FIRST : 16'h0000);
                    byte_d = {1'b0, byte_q[7:1]};
                end
                bitcnt_d = bitcnt_q + 3'h1;
                if (bitcnt_q == 3'h7) begin
                    crc_st_d = CRC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_st_q <= CRC_IDLE;
            crc_q    <= 16'h0000;
            byte_q   <= 8'h00;
            bitcnt_q <= 3'h0;
            order_q  <= 1'b0;
            alive_q  <= 2'h0;
        end else begin
            crc_st_q <= crc_st_d;
            crc_q    <= crc_d;
            byte_q   <= byte_d;
            bitcnt_q <= bitcnt_d;
            order_q  <= order_d;
            alive_q  <= (alive_q == 2'h3) ? alive_q : alive_q + 2'h1;
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_rev
        assign rev_hi[i] = crc_q[15-i];
        assign rev_lo[i] = crc_q[7-i];
    end

    assign crc_ready       = crc_st_q == CRC_IDLE;
    assign crc_result_high = order_q ? rev_hi : crc_q[15:8]; // see R2
    assign crc_result_low  = order_q ? rev_lo : crc_q[7:0]; // see R2

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_order_taken;
        crc_ready && crc_compute_command && !rf_active && gen_q.crc_high_bit_order
            |=> order_q;
    endproperty
    a_order_taken: assert property (p_order_taken) else $error("msb order not taken"); // see R1

    property p_result_reversed;
        order_q |-> crc_result_high[0] == crc_q[15] && crc_result_low[7] == crc_q[0];
    endproperty
    a_result_reversed: assert property (p_result_reversed) else $error("result not reversed"); // see R2

    property p_order_ignored_rf;
        crc_ready && crc_compute_command && rf_active |=> !order_q;
    endproperty
    a_order_ignored_rf: assert property (p_order_ignored_rf) else $error("order used in rf"); // see R3

    property p_wait_field;
        tx_start_req && gen_q.transmit_wait_for_field && !rf_field_on |-> !tx_start_grant;
    endproperty
    a_wait_field: assert property (p_wait_field) else $error("start without field"); // see R4

    property p_env_polarity;
        alive_q == 2'h3 && $stable(gen_q.envelope_input_polarity)
            |-> envelope_n == ($past(envelope_input_pin, 3) ^ gen_q.envelope_input_polarity);
    endproperty
    a_env_polarity: assert property (p_env_polarity) else $error("envelope polarity wrong"); // see R5

    property p_env_event;
        $changed(gen_q.envelope_input_polarity) |-> envelope_input_active_event;
    endproperty
    a_env_event: assert property (p_env_event) else $error("no envelope event"); // see R6

    property p_preset_std;
        crc_ready && crc_compute_command && !rf_active && gen_q.crc_init_select == 2'h2
            |=> {crc_result_high, crc_result_low} == PRESET_2 || order_q;
    endproperty
    a_preset_std: assert property (p_preset_std) else $error("standalone preset wrong"); // see R7

    property p_preset_rf;
        crc_ready && crc_compute_command && rf_active && tx_active
            && tx_q.transmit_frame_format == FRAME_B |=> crc_q == PRESET_3;
    endproperty
    a_preset_rf: assert property (p_preset_rf) else $error("rf preset wrong"); // see R8

    property p_crc_en_write;
        reg_we && reg_addr == TX_MODE_ADDR ##1 1'b1
            |-> tx_settings.transmit_crc_enable == $past(reg_wdata[TX_CRC_BIT]);
    endproperty
    a_crc_en_write: assert property (p_crc_en_write) else $error("crc enable not stored"); // see R9

    property p_tick_848;
        tx_bit_tick && tx_active && tx_q.transmit_bit_rate == 3'(RATE_848)
            && $stable(tx_q.transmit_bit_rate) |=> !tx_bit_tick [*8];
    endproperty
    a_tick_848: assert property (p_tick_848) else $error("848 tick too close"); // see R11

    property p_mod_invert;
        alive_q == 2'h3 |-> tx_mod_out == $past(tx_data_mod ^ tx_q.modulation_invert);
    endproperty
    a_mod_invert: assert property (p_mod_invert) else $error("modulation polarity wrong"); // see R12

    c_msb_crc:   cover property (crc_ready && crc_compute_command && !rf_active
                                 && gen_q.crc_high_bit_order);
    c_byte_done: cover property (crc_st_q == CRC_RUN && bitcnt_q == 3'h7);
    c_blocked:   cover property (tx_start_req && !tx_start_grant);
    c_env_evt:   cover property (envelope_input_active_event);
endmodule // rf_tx_crc_mode_config
`default_nettype wire

// file: rf_host_model.sv
// host processor model driving the register access strobes
`timescale 1ns/1ns
`default_nettype none
module rf_host_model
    import rf_tx_crc_mode_config_pkg::*;
(
    // clock
    input  wire logic       clk,
    // register access
    output var  logic [5:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_we,
    output var  logic       reg_re,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end

    // raw skips the host's own legality fixes
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d, input bit raw);
        logic [7:0] v;
        v = d;
        if (!raw && a == GEN_MODE_ADDR) begin
            v = (d & ~GEN_RSVD_MASK) | (GEN_MODE_RESET & GEN_RSVD_MASK);
        end
        if (!raw && a == TX_MODE_ADDR && d[6:4] != 3'h0) begin
            v[7] = 1'b1;
        end
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_we = 1'b1;
        @(posedge clk);
        #1;
        reg_we = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask

    task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_re = 1'b1;
        @(posedge clk);
        #1;
        reg_re = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule // rf_host_model
`default_nettype wire

// file: rf_tx_crc_mode_config_test.sv
// self-checking testbench for the mode and transmit mode configuration block
`timescale 1ns/1ns
`default_nettype none
module rf_tx_crc_mode_config_test
    import rf_tx_crc_mode_config_pkg::*;
;
    logic clk, reset_n, rf_active, tx_active, rf_field_on, tx_start_req, tx_data_mod;
    logic envelope_input_pin, crc_compute_command, crc_data_valid;
    logic [1:0] receive_frame_format;
    logic [7:0] crc_data, reg_rdata, reg_wdata, crc_result_high, crc_result_low;
    logic [5:0] reg_addr;
    logic reg_we, reg_re, tx_code_reserved, tx_start_grant, tx_bit_tick, tx_mod_out;
    logic envelope_n, envelope_input_active_event, crc_ready;
    gen_settings_t gen_settings;
    tx_settings_t tx_settings;
    int mismatches = 0;
    int compares = 0;
    int n;
    logic [15:0] presets [4] = '{PRESET_0, PRESET_1, PRESET_2, PRESET_3};
    logic [7:0] tx_raw [6] = '{8'h71, 8'h81, 8'h82, 8'h80, 8'h83, 8'h30};
    logic tx_rsv [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0] tick_cyc [5] = '{BIT_106_CYC, BIT_212_CYC, BIT_424_CYC, BIT_848_CYC, BIT_106_CYC};

    rf_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

    rf_tx_crc_mode_config dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .gen_settings(gen_settings), .tx_settings(tx_settings),
        .tx_code_reserved(tx_code_reserved), .rf_active(rf_active), .tx_active(tx_active),
        .receive_frame_format(receive_frame_format), .rf_field_on(rf_field_on),
        .tx_start_req(tx_start_req), .tx_start_grant(tx_start_grant),
        .tx_bit_tick(tx_bit_tick), .tx_data_mod(tx_data_mod), .tx_mod_out(tx_mod_out),
        .envelope_input_pin(envelope_input_pin), .envelope_n(envelope_n),
        .envelope_input_active_event(envelope_input_active_event),
        .crc_compute_command(crc_compute_command), .crc_data(crc_data),
        .crc_data_valid(crc_data_valid), .crc_ready(crc_ready),
        .crc_result_high(crc_result_high), .crc_result_low(crc_result_low));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d, input bit raw);
        host_u.write_reg(a, d, raw);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_u.read_reg(a, v);
        check({8'h00, v}, {8'h00, exp}, "register read");
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic bounded(input int lim);
        if (n >= lim) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    task automatic to_tick();
        n = 0;
        do begin
            step();
            n++;
        end while (tx_bit_tick !== 1'b1 && n < 400);
        bounded(400);
    endtask

    task automatic crc_cmd();
        step();
        crc_compute_command = 1'b1;
        step();
        crc_compute_command = 1'b0;
    endtask

    task automatic crc_byte(input logic [7:0] b);
        step();
        crc_data = b;
        crc_data_valid = 1'b1;
        step();
        crc_data_valid = 1'b0;
        crc_data = ~b;
        n = 0;
        while (crc_ready !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        bounded(20);
    endtask

    function automatic logic [15:0] crc_lsb(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ POLY_LSB_FIRST) : (c >> 1);
        return c;
    endfunction

    function automatic logic [15:0] crc_msb(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ POLY_MSB_FIRST) : (c << 1);
        return c;
    endfunction

    function automatic logic [15:0] rev(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
            r[8 + i] = v[15 - i];
        end
        return r;
    endfunction

    initial begin
        {reset_n, rf_active, tx_active, rf_field_on, tx_start_req, tx_data_mod} = 6'h00;
        {envelope_input_pin, crc_compute_command, crc_data_valid} = 3'h0;
        receive_frame_format = 2'h0;
        crc_data = 8'h00;
        repeat (4) @(posedge clk);
        #1;
        reset_n = 1'b1;
        rd(GEN_MODE_ADDR, GEN_MODE_RESET);
        rd(TX_MODE_ADDR, TX_MODE_RESET);
        rd(6'h13, 8'h00);
        tx_start_req = 1'b1;
        step();
        check({15'h0, tx_start_grant}, 16'h0, "grant no field");
        rf_field_on = 1'b1;
        step();
        check({15'h0, tx_start_grant}, 16'h1, "grant field");
        rf_field_on = 1'b0;
        wr(GEN_MODE_ADDR, 8'h1F, 1'b0);
        check({15'h0, tx_start_grant}, 16'h1, "grant no wait");
        check({15'h0, envelope_n}, 16'h1, "envelope idle");
        envelope_input_pin = 1'b1;
        repeat (3) step();
        check({15'h0, envelope_n}, 16'h0, "envelope active high");
        wr(GEN_MODE_ADDR, 8'h17, 1'b0);
        check({15'h0, envelope_input_active_event}, 16'h1, "event");
        step();
        check({15'h0, envelope_input_active_event}, 16'h0, "event end");
        check({15'h0, envelope_n}, 16'h1, "envelope low pol");
        envelope_input_pin = 1'b0;
        repeat (3) step();
        check({15'h0, envelope_n}, 16'h0, "envelope active low");
        wr(GEN_MODE_ADDR, 8'h17, 1'b0);
        check({15'h0, envelope_input_active_event}, 16'h0, "no event");
        tx_data_mod = 1'b1;
        step();
        check({15'h0, tx_mod_out}, 16'h1, "mod plain");
        wr(TX_MODE_ADDR, 8'h08, 1'b0);
        step();
        check({15'h0, tx_mod_out}, 16'h0, "mod inverted");
        wr(TX_MODE_ADDR, 8'hBB, 1'b0);
        rd(TX_MODE_ADDR, 8'hBB);
        check({9'h0, tx_settings}, 16'h005F, "tx fields");
        for (int i = 0; i < 6; i++) begin
            wr(TX_MODE_ADDR, tx_raw[i], 1'b1);
            check({15'h0, tx_code_reserved}, {15'h0, tx_rsv[i]}, "reserved code");
        end
        wr(TX_MODE_ADDR, 8'hFF, 1'b1);
        rd(TX_MODE_ADDR, 8'hFB);
        wr(GEN_MODE_ADDR, 8'h00, 1'b1);
        rd(GEN_MODE_ADDR, 8'h14);
        check({11'h0, gen_settings}, 16'h0000, "gen fields");
        wr(GEN_MODE_ADDR, 8'hFF, 1'b1);
        rd(GEN_MODE_ADDR, 8'hBF);
        check({11'h0, gen_settings}, 16'h001F, "gen fields");
        wr(6'h13, 8'hAA, 1'b1);
        rd(6'h13, 8'h00);
        rd(GEN_MODE_ADDR, 8'hBF);
        wr(TX_MODE_ADDR, 8'h80, 1'b0);
        for (int p = 0; p < 4; p++) begin
            wr(GEN_MODE_ADDR, 8'(p), 1'b0);
            crc_cmd();
            check({crc_result_high, crc_result_low}, presets[p], "preset");
        end
        wr(GEN_MODE_ADDR, 8'h01, 1'b0);
        crc_cmd();
        crc_byte(8'h12);
        check({crc_result_high, crc_result_low}, crc_lsb(PRESET_1, 8'h12), "crc lsb");
        wr(GEN_MODE_ADDR, 8'h82, 1'b0);
        crc_cmd();
        check({crc_result_high, crc_result_low}, rev(PRESET_2), "preset msb");
        crc_byte(8'h34);
        check({crc_result_high, crc_result_low}, rev(crc_msb(PRESET_2, 8'h34)), "crc msb");
        rf_active = 1'b1;
        receive_frame_format = 2'h3;
        wr(GEN_MODE_ADDR, 8'h80, 1'b0);
        crc_cmd();
        check({crc_result_high, crc_result_low}, PRESET_3, "auto preset b");
        tx_active = 1'b1;
        crc_cmd();
        check({crc_result_high, crc_result_low}, PRESET_1, "auto preset a");
        wr(TX_MODE_ADDR, 8'h83, 1'b0);
        crc_cmd();
        check({crc_result_high, crc_result_low}, PRESET_3, "auto preset tx b");
        rf_active = 1'b0;
        for (int c = 0; c < 5; c++) begin
            wr(TX_MODE_ADDR, {1'b1, 3'(c), 4'h0}, 1'b1);
            to_tick();
            to_tick();
            to_tick();
            check(16'(n), {8'h00, tick_cyc[c]}, "tick period");
        end
        report_and_stop();
    end
endmodule // rf_tx_crc_mode_config_test
`default_nettype wire
